// [peripheral_port_handshake_lines.sv]
// Two-port parallel adapter with handshake control lines, AHB-Lite slave.
// Assumes a single AHB-Lite master; hready is this slave's hreadyout.
`timescale 1ns/1ps

module peripheral_port_handshake_lines (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] port_a_lines_in,
   output adapter_pkg::port_drive_t port_a_lines,
   input wire logic [7:0] port_b_lines_in,
   output adapter_pkg::port_drive_t port_b_lines,
   input wire logic a_first_control_input,
   input wire logic b_first_control_input,
   input wire logic a_second_control_line_in,
   output adapter_pkg::line_drive_t a_second_control_line,
   input wire logic b_second_control_line_in,
   output adapter_pkg::line_drive_t b_second_control_line,
   output logic a_interrupt_out_n,
   output logic b_interrupt_out_n
);
   import adapter_pkg::*;

   // ***************************************
   // Storage
   // ***************************************
   logic [7:0] side_a_control;
   logic [7:0] side_b_control;
   logic [7:0] data_a;
   logic [7:0] data_b;
   logic [7:0] dir_a;
   logic [7:0] dir_b;
   logic [7:0] pin_a_s1;
   logic [7:0] pin_a_s2;
   logic [7:0] pin_b_s1;
   logic [7:0] pin_b_s2;
   logic wr_pend;
   logic [7:0] wr_addr;

   logic [7:0] next_side_a_control;
   logic [7:0] next_side_b_control;
   logic [7:0] next_data_a;
   logic [7:0] next_data_b;
   logic [7:0] next_dir_a;
   logic [7:0] next_dir_b;
   logic next_wr_pend;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic next_a_interrupt_out_n;
   logic next_b_interrupt_out_n;

   logic addr_take;
   logic rd_take;
   logic a_read;
   logic b_read;
   logic b_write;
   logic a1_edge;
   logic b1_edge;
   logic a2_edge;
   logic b2_edge;
   logic a_line_out;
   logic b_line_out;
   logic [7:0] rd_value;

   // ***************************************
   // Control line edge detection
   // ***************************************
   edge_catch u_a_first (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(a_first_control_input),
      .rising(side_a_control[BIT_FIRST_RISING]),
      .edge_seen(a1_edge)
   );

   edge_catch u_b_first (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(b_first_control_input),
      .rising(side_b_control[BIT_FIRST_RISING]),
      .edge_seen(b1_edge)
   );

   edge_catch u_a_second (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(a_second_control_line_in),
      .rising(side_a_control[BIT_SECOND_RISING]),
      .edge_seen(a2_edge)
   );

   edge_catch u_b_second (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(b_second_control_line_in),
      .rising(side_b_control[BIT_SECOND_RISING]),
      .edge_seen(b2_edge)
   );

   // ***************************************
   // Second line output modes
   // ***************************************
   line_driver u_a_line (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(side_a_control[MODE_MSB:MODE_LSB]),
      .first_edge(a1_edge),
      .access(a_read),
      .line_out(a_line_out)
   );

   line_driver u_b_line (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(side_b_control[MODE_MSB:MODE_LSB]),
      .first_edge(b1_edge),
      .access(b_write),
      .line_out(b_line_out)
   );

   // ***************************************
   // Bus decode
   // ***************************************
   always_comb begin
      addr_take = hsel & hready & htrans[1];
      rd_take = addr_take & ~hwrite;
      a_read = rd_take && (haddr[7:0] == OFS_PORT_A_DATA);
      b_read = rd_take && (haddr[7:0] == OFS_PORT_B_DATA);
      b_write = wr_pend && hready && (wr_addr == OFS_PORT_B_DATA);
      next_wr_pend = addr_take & hwrite;
      next_wr_addr = haddr[7:0];
   end

   // ***************************************
   // Register update
   // ***************************************
   always_comb begin
      next_data_a = data_a;
      next_data_b = data_b;
      next_dir_a = dir_a;
      next_dir_b = dir_b;
      next_side_a_control = side_a_control;
      next_side_b_control = side_b_control;
      if (wr_pend && hready) begin
         case (wr_addr)
            OFS_PORT_A_DATA: next_data_a = hwdata[7:0];
            OFS_PORT_A_DIR: next_dir_a = hwdata[7:0];
            OFS_PORT_B_DATA: next_data_b = hwdata[7:0];
            OFS_PORT_B_DIR: next_dir_b = hwdata[7:0];
            OFS_SIDE_A_CONTROL: next_side_a_control =
               (side_a_control & ~CTRL_WRITE_MASK)
               | (hwdata[7:0] & CTRL_WRITE_MASK);
            OFS_SIDE_B_CONTROL: next_side_b_control =
               (side_b_control & ~CTRL_WRITE_MASK)
               | (hwdata[7:0] & CTRL_WRITE_MASK);
            default: ;
         endcase
      end
      // Flags: a new edge wins over the clearing read
      next_side_a_control[BIT_FIRST_FLAG] = a1_edge
         | (side_a_control[BIT_FIRST_FLAG] & ~a_read);
      next_side_b_control[BIT_FIRST_FLAG] = b1_edge
         | (side_b_control[BIT_FIRST_FLAG] & ~b_read);
      next_side_a_control[BIT_SECOND_FLAG] =
         (a2_edge & ~side_a_control[BIT_SECOND_OUTPUT])
         | (side_a_control[BIT_SECOND_FLAG] & ~a_read);
      next_side_b_control[BIT_SECOND_FLAG] =
         (b2_edge & ~side_b_control[BIT_SECOND_OUTPUT])
         | (side_b_control[BIT_SECOND_FLAG] & ~b_read);
   end

   // ***************************************
   // Interrupt outputs
   // ***************************************
   always_comb begin
      next_a_interrupt_out_n = ~(
         (side_a_control[BIT_FIRST_FLAG] & side_a_control[BIT_FIRST_IRQ_EN])
         | (side_a_control[BIT_SECOND_FLAG]
            & side_a_control[BIT_SECOND_IRQ_EN]
            & ~side_a_control[BIT_SECOND_OUTPUT]));
      next_b_interrupt_out_n = ~(
         (side_b_control[BIT_FIRST_FLAG] & side_b_control[BIT_FIRST_IRQ_EN])
         | (side_b_control[BIT_SECOND_FLAG]
            & side_b_control[BIT_SECOND_IRQ_EN]
            & ~side_b_control[BIT_SECOND_OUTPUT]));
   end

   // ***************************************
   // Read data, taken from the updated values
   // ***************************************
   always_comb begin
      rd_value = 8'h00;
      case (haddr[7:0])
         OFS_PORT_A_DATA:
            rd_value = (next_data_a & next_dir_a) | (pin_a_s2 & ~next_dir_a);
         OFS_PORT_A_DIR: rd_value = next_dir_a;
         OFS_SIDE_A_CONTROL: rd_value = next_side_a_control;
         OFS_PORT_B_DATA:
            rd_value = (next_data_b & next_dir_b) | (pin_b_s2 & ~next_dir_b);
         OFS_PORT_B_DIR: rd_value = next_dir_b;
         OFS_SIDE_B_CONTROL: rd_value = next_side_b_control;
         default: rd_value = 8'h00;
      endcase
      next_hrdata = rd_take ? {24'h00_0000, rd_value} : hrdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         side_a_control <= CTRL_RESET;
         side_b_control <= CTRL_RESET;
         data_a <= DATA_RESET;
         data_b <= DATA_RESET;
         dir_a <= DIR_RESET;
         dir_b <= DIR_RESET;
         pin_a_s1 <= DATA_RESET;
         pin_a_s2 <= DATA_RESET;
         pin_b_s1 <= DATA_RESET;
         pin_b_s2 <= DATA_RESET;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= RDATA_RESET;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
         a_interrupt_out_n <= 1'b1;
         b_interrupt_out_n <= 1'b1;
      end else begin
         side_a_control <= next_side_a_control;
         side_b_control <= next_side_b_control;
         data_a <= next_data_a;
         data_b <= next_data_b;
         dir_a <= next_dir_a;
         dir_b <= next_dir_b;
         pin_a_s1 <= port_a_lines_in;
         pin_a_s2 <= pin_a_s1;
         pin_b_s1 <= port_b_lines_in;
         pin_b_s2 <= pin_b_s1;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
         a_interrupt_out_n <= next_a_interrupt_out_n;
         b_interrupt_out_n <= next_b_interrupt_out_n;
      end
   end

   // ***************************************
   // Pin drive
   // ***************************************
   assign port_a_lines = '{out: data_a, oe: dir_a};
   assign port_b_lines = '{out: data_b, oe: dir_b};
   assign a_second_control_line = '{out: a_line_out,
      oe: side_a_control[BIT_SECOND_OUTPUT]};
   assign b_second_control_line = '{out: b_line_out,
      oe: side_b_control[BIT_SECOND_OUTPUT]};

   // ***************************************
   // Assertions
   // ***************************************
   sequence s_a_pulse_read;
      side_a_control[MODE_MSB:MODE_LSB] == LINE_PULSE && a_read;
   endsequence

   sequence s_b_pulse_write;
      side_b_control[MODE_MSB:MODE_LSB] == LINE_PULSE && b_write;
   endsequence

   a_first_flag_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      a1_edge |=> side_a_control[BIT_FIRST_FLAG])
      else $error("first input edge did not set flag");

   a_irq_follows_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_b_control[BIT_FIRST_FLAG] && side_b_control[BIT_FIRST_IRQ_EN]
      |=> !b_interrupt_out_n)
      else $error("enabled flag did not pull irq low");

   a_irq_masked_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !side_a_control[BIT_FIRST_IRQ_EN]
      && !side_a_control[BIT_SECOND_IRQ_EN] |=> a_interrupt_out_n)
      else $error("disabled irq went low");

   a_second_flag_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      b2_edge && !side_b_control[BIT_SECOND_OUTPUT]
      |=> side_b_control[BIT_SECOND_FLAG])
      else $error("second input edge did not set flag");

   a_second_irq_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_a_control[BIT_SECOND_FLAG] && side_a_control[BIT_SECOND_IRQ_EN]
      && !side_a_control[BIT_SECOND_OUTPUT] |=> !a_interrupt_out_n)
      else $error("second flag did not pull irq low");

   a_hsk_read_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_a_control[MODE_MSB:MODE_LSB] == LINE_HANDSHAKE
      && a_read && !a1_edge
      |=> !a_line_out)
      else $error("read handshake line not low");

   a_pulse_read_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_a_pulse_read ##1 (side_a_control[MODE_MSB:MODE_LSB] == LINE_PULSE
      && !a_read) |-> !a_line_out ##1 a_line_out)
      else $error("read pulse not one cycle low");

   a_manual_a_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_a_control[MODE_MSB:MODE_MSB - 1] == 2'b11
      |=> a_line_out == $past(side_a_control[MODE_LSB]))
      else $error("manual A line level wrong");

   a_hsk_write_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_b_control[MODE_MSB:MODE_LSB] == LINE_HANDSHAKE && b_write
      && !b1_edge |=> !b_line_out)
      else $error("write handshake line not low");

   a_hsk_write_rise: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_b_control[MODE_MSB:MODE_LSB] == LINE_HANDSHAKE && b1_edge
      |=> b_line_out)
      else $error("write handshake line not raised");

   a_pulse_write_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_b_pulse_write ##1 (side_b_control[MODE_MSB:MODE_LSB] == LINE_PULSE
      && !b_write) |-> !b_line_out ##1 b_line_out)
      else $error("write pulse not one cycle low");

   a_manual_b_line: assert property (
      @(posedge hclk) disable iff (!hresetn)
      side_b_control[MODE_MSB:MODE_MSB - 1] == 2'b11
      |=> b_line_out == $past(side_b_control[MODE_LSB]))
      else $error("manual B line level wrong");

   a_read_clears_flags: assert property (
      @(posedge hclk) disable iff (!hresetn)
      a_read && !a1_edge && !a2_edge
      |=> !side_a_control[BIT_FIRST_FLAG] && !side_a_control[BIT_SECOND_FLAG])
      else $error("data read did not clear flags");

   a_reset_control_zero: assert property (
      @(posedge hclk)
      $rose(hresetn) |-> side_a_control == CTRL_RESET
      && side_b_control == CTRL_RESET)
      else $error("control not zero after reset");

endmodule

// [adapter_pkg.sv]
// Constants, types and register map of the parallel port adapter.
// Assumes one AHB-Lite clock domain; pins are synchronised inside the block.

package adapter_pkg;

   // ***************************************
   // Register byte offsets
   // ***************************************
   localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
   localparam logic [7:0] OFS_PORT_A_DIR = 8'h04;
   localparam logic [7:0] OFS_SIDE_A_CONTROL = 8'h08;
   localparam logic [7:0] OFS_PORT_B_DATA = 8'h0C;
   localparam logic [7:0] OFS_PORT_B_DIR = 8'h10;
   localparam logic [7:0] OFS_SIDE_B_CONTROL = 8'h14;

   // ***************************************
   // Control register fields
   // ***************************************
   localparam int BIT_FIRST_IRQ_EN = 0;
   localparam int BIT_FIRST_RISING = 1;
   localparam int BIT_SECOND_IRQ_EN = 3;
   localparam int BIT_SECOND_RISING = 4;
   localparam int BIT_SECOND_OUTPUT = 5;
   localparam int BIT_SECOND_FLAG = 6;
   localparam int BIT_FIRST_FLAG = 7;
   localparam int MODE_LSB = 3;
   localparam int MODE_MSB = 5;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h3F;

   // ***************************************
   // Reset values
   // ***************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   localparam logic LINE_OUT_RESET = 1'b1;

   // ***************************************
   // Bus encodings
   // ***************************************
   localparam logic HRESP_OKAY = 1'b0;

   // Second line output modes
   typedef enum logic [2:0] {
      LINE_HANDSHAKE = 3'b100,
      LINE_PULSE = 3'b101,
      LINE_LOW = 3'b110,
      LINE_HIGH = 3'b111
   } line_mode_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } port_drive_t;

   typedef struct packed {
      logic out;
      logic oe;
   } line_drive_t;

endpackage

// [edge_catch.sv]
// Synchroniser and selectable edge detector for one control input.
// Assumes the raw input is asynchronous to hclk.
`timescale 1ns/1ps

module edge_catch (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic raw,
   input wire logic rising,
   output logic edge_seen
);
   logic sync1;
   logic sync2;
   logic last;
   logic next_sync1;
   logic next_sync2;
   logic next_last;

   always_comb begin
      next_sync1 = raw;
      next_sync2 = sync1;
      next_last = sync2;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         last <= 1'b0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         last <= next_last;
      end
   end

   // Edge polarity chosen by the control bit
   assign edge_seen = rising ? (sync2 & ~last) : (~sync2 & last);

endmodule

// [line_driver.sv]
// Output level of one second control line in its output modes.
// Assumes edge and access are one-cycle pulses on hclk.
`timescale 1ns/1ps

module line_driver
   import adapter_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] mode,
   input wire logic first_edge,
   input wire logic access,
   output logic line_out
);
   logic next_line_out;

   always_comb begin
      next_line_out = line_out;
      unique case (line_mode_t'(mode))
         // Peripheral edge wins a tie with the access
         LINE_HANDSHAKE: begin
            if (first_edge) begin
               next_line_out = 1'b1;
            end else if (access) begin
               next_line_out = 1'b0;
            end
         end
         LINE_PULSE: next_line_out = ~access;
         LINE_LOW: next_line_out = 1'b0;
         LINE_HIGH: next_line_out = 1'b1;
         // Input modes: idle high, pin not driven
         default: next_line_out = LINE_OUT_RESET;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_out <= LINE_OUT_RESET;
      end else begin
         line_out <= next_line_out;
      end
   end

endmodule

// [peripheral_model.sv]
// Peripheral on the far side: control inputs, second lines, port pins.
// Assumes the bench calls its tasks; levels change after a rising edge.
`timescale 1ns/1ps

module peripheral_model (
   input wire logic hclk,
   input wire adapter_pkg::port_drive_t port_a_lines,
   input wire adapter_pkg::port_drive_t port_b_lines,
   input wire adapter_pkg::line_drive_t a_second_control_line,
   input wire adapter_pkg::line_drive_t b_second_control_line,
   output logic [7:0] port_a_lines_in,
   output logic [7:0] port_b_lines_in,
   output logic a_first_control_input,
   output logic b_first_control_input,
   output logic a_second_control_line_in,
   output logic b_second_control_line_in
);
   import adapter_pkg::*;

   logic [1:0] first;
   logic [1:0] second;
   logic [7:0] pins_a;
   logic [7:0] pins_b;

   initial begin
      first = 2'b11;
      second = 2'b11;
      pins_a = 8'h00;
      pins_b = 8'h00;
   end

   // ***************************************
   // Wire levels from all drivers
   // ***************************************
   assign port_a_lines_in = (port_a_lines.out & port_a_lines.oe)
                            | (pins_a & ~port_a_lines.oe);
   assign port_b_lines_in = (port_b_lines.out & port_b_lines.oe)
                            | (pins_b & ~port_b_lines.oe);
   assign a_first_control_input = first[0];
   assign b_first_control_input = first[1];
   assign a_second_control_line_in = a_second_control_line.oe ?
                                     a_second_control_line.out : second[0];
   assign b_second_control_line_in = b_second_control_line.oe ?
                                     b_second_control_line.out : second[1];

   // Level held long enough to pass the synchroniser
   task automatic set_line(input int s, input int w, input logic v);
      @(posedge hclk);
      if (w == 0) begin
         first[s] <= v;
      end else begin
         second[s] <= v;
      end
      repeat (6) @(posedge hclk);
   endtask

   task automatic set_pins(input logic [7:0] a, input logic [7:0] b);
      @(posedge hclk);
      pins_a <= a;
      pins_b <= b;
      repeat (4) @(posedge hclk);
   endtask
endmodule

// [test_peripheral_port_handshake_lines.sv]
// Self-checking bench of the handshake line adapter over AHB-Lite.
// Assumes peripheral_model on the pins; hready is the slave's hreadyout.
`timescale 1ns/1ps

module test_peripheral_port_handshake_lines;
   import adapter_pkg::*;

   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pa_in, pb_in, cfg, v, dir, pins;
   logic a_first, b_first, a_sec_in, b_sec_in, irq_a_n, irq_b_n, rise, en;
   port_drive_t port_a_lines, port_b_lines;
   line_drive_t a_line, b_line;
   int mismatches = 0;
   int total_checks = 0;
   int lows [2] = '{0, 0};
   int start;
   logic [7:0] ofs_data [2] = '{OFS_PORT_A_DATA, OFS_PORT_B_DATA};
   logic [7:0] ofs_dir [2] = '{OFS_PORT_A_DIR, OFS_PORT_B_DIR};
   logic [7:0] ofs_ctrl [2] = '{OFS_SIDE_A_CONTROL, OFS_SIDE_B_CONTROL};

   peripheral_port_handshake_lines u_peripheral_port_handshake_lines (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .port_a_lines_in(pa_in),
      .port_a_lines(port_a_lines), .port_b_lines_in(pb_in),
      .port_b_lines(port_b_lines), .a_first_control_input(a_first),
      .b_first_control_input(b_first), .a_second_control_line_in(a_sec_in),
      .a_second_control_line(a_line), .b_second_control_line_in(b_sec_in),
      .b_second_control_line(b_line), .a_interrupt_out_n(irq_a_n),
      .b_interrupt_out_n(irq_b_n));

   peripheral_model u_peripheral_model (
      .hclk(hclk), .port_a_lines(port_a_lines), .port_b_lines(port_b_lines),
      .a_second_control_line(a_line), .b_second_control_line(b_line),
      .port_a_lines_in(pa_in), .port_b_lines_in(pb_in),
      .a_first_control_input(a_first), .b_first_control_input(b_first),
      .a_second_control_line_in(a_sec_in),
      .b_second_control_line_in(b_sec_in));

   initial hclk = 1'b0;
   always #50 hclk = ~hclk;

   always @(posedge hclk) begin
      lows[0] += (a_line.out === 1'b0);
      lows[1] += (b_line.out === 1'b0);
   end

   // ***************************************
   // Checking and bus tasks
   // ***************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            mismatches++;
            stop_test();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      bus(1'b0, a, 8'h00, x);
   endtask

   task automatic line_is(input int s, input logic exp);
      repeat (2) @(posedge hclk);
      check("line out", s ? b_line.out : a_line.out, exp);
      check("line oe", s ? b_line.oe : a_line.oe, 1'b1);
   endtask

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      stop_test();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      start = $urandom(32'h56EC8765);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("irq", {irq_a_n, irq_b_n}, 2'b11);
      check("line", {a_line, b_line}, 4'b1010);
      for (int r = 0; r < 7; r++) begin
         rd(8'(r * 4), d);
         check("reset reg", d, 32'h00000000);
      end
      wr(8'h18, 8'h5A);
      rd(8'h18, d);
      check("unmapped", d, 32'h00000000);
      wr(OFS_SIDE_A_CONTROL, 8'hFF);
      rd(OFS_SIDE_A_CONTROL, d);
      check("flags read only", d, 32'h0000003F);
      pins = 8'($urandom);
      u_peripheral_model.set_pins(pins, ~pins);
      for (int s = 0; s < 2; s++) begin
         v = 8'($urandom);
         dir = 8'($urandom);
         wr(ofs_dir[s], dir);
         wr(ofs_data[s], v);
         rd(ofs_dir[s], d);
         check("dir", d, {24'h0, dir});
         check("port", s ? port_b_lines : port_a_lines, {v, dir});
         rd(ofs_data[s], d);
         v = (v & dir) | ((s ? ~pins : pins) & ~dir);
         check("data", d, {24'h0, v});
      end
      for (int s = 0; s < 2; s++) begin
         for (int w = 0; w < 2; w++) begin
            for (int k = 0; k < 4; k++) begin
               rise = k[1];
               en = k[0];
               cfg = w ? {3'b000, rise, en, 3'b000} : {6'b0, rise, en};
               wr(ofs_ctrl[s], cfg);
               rd(ofs_data[s], d);
               u_peripheral_model.set_line(s, w, ~rise);
               rd(ofs_ctrl[s], d);
               check("flag idle", d, {24'h0, cfg});
               u_peripheral_model.set_line(s, w, rise);
               rd(ofs_ctrl[s], d);
               check("flag", d, {24'h0, cfg | (w ? 8'h40 : 8'h80)});
               check("irq", s ? irq_b_n : irq_a_n, !en);
               rd(ofs_data[s], d);
               rd(ofs_ctrl[s], d);
               check("flag clear", d, {24'h0, cfg});
               check("irq clear", s ? irq_b_n : irq_a_n, 1'b1);
            end
         end
      end
      wr(OFS_SIDE_A_CONTROL, 8'h20);
      rd(OFS_PORT_A_DATA, d);
      line_is(0, 1'b0);
      u_peripheral_model.set_line(0, 0, 1'b0);
      line_is(0, 1'b1);
      rd(OFS_PORT_A_DATA, d);
      line_is(0, 1'b0);
      wr(OFS_SIDE_B_CONTROL, 8'h20);
      wr(OFS_PORT_B_DATA, 8'($urandom));
      line_is(1, 1'b0);
      u_peripheral_model.set_line(1, 0, 1'b0);
      line_is(1, 1'b1);
      wr(OFS_PORT_B_DATA, 8'($urandom));
      line_is(1, 1'b0);
      for (int s = 0; s < 2; s++) begin
         wr(ofs_ctrl[s], 8'h28);
         repeat (3) @(negedge hclk);
         start = lows[s];
         if (s == 0) rd(OFS_PORT_A_DATA, d);
         else wr(OFS_PORT_B_DATA, 8'($urandom));
         repeat (4) @(negedge hclk);
         check("pulse", lows[s] - start, 1);
         line_is(s, 1'b1);
         for (int m = 0; m < 2; m++) begin
            wr(ofs_ctrl[s], 8'h30 | 8'(m << 3));
            line_is(s, m[0]);
         end
      end
      stop_test();
   end
endmodule
